/* File: hw/tdp_debug_port.sv */
// two-wire debug port controller: session, pin borrowing, led block, reset and boot
`timescale 1ns/10ps
`include "tdp_defines.svh"
module tdp_debug_port (
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    input  wire logic [`TDP_GPIO_W-1:0] gpio_pin_i,
    input  wire logic                   user_led_req_i,
    input  wire logic                   user_dat_out_i,
    input  wire logic                   user_dat_oe_i,
    input  wire tdp_pkg::tdp_part_t     part_state_i,
    input  wire logic                   debug_disable_i,
    input  wire logic                   shutdown_req_i,
    input  wire logic                   boot_done_i,
    output logic [`TDP_GPIO_W-1:0]      gpio_in_o,
    output logic                        dat_pin_o,
    output logic                        dat_pin_oe,
    output logic                        led_drive_o,
    output logic                        core_halt_o,
    output logic                        bp_clear_o,
    output logic                        dig_rst_n_o,
    output logic                        boot_req_o,
    output logic                        boot_user_load_o,
    output logic                        ram_keep_o,
    output logic                        pwr_off_o
);
    import tdp_pkg::*;

    logic [`TDP_GPIO_W-1:0] gpio_meta_q;
    logic [`TDP_GPIO_W-1:0] gpio_sync_q;
    logic                   session_q;
    logic                   session_d;
    logic                   ack_valid_q;
    logic                   ack_q;
    logic                   bp_clear_q;
    tdp_boot_st_t           st_q;
    logic [3:0]             rst_cnt_q;
    logic                   dig_rst_n_q;
    logic                   boot_req_q;
    logic                   user_load_q;
    logic                   ram_keep_q;
    logic                   pwr_off_q;
    logic                   led_q;
    logic                   dat_o_q;
    logic                   dat_oe_q;
    logic                   locked;
    logic                   wake;
    logic                   take_connect;
    logic                   take_disc;
    logic                   take_reset;

    tdp_link_if lnk ();

    function automatic logic is_cmd(input logic vld, input logic [7:0] cmd, input logic [7:0] code);
        is_cmd = vld && (cmd == code);
    endfunction

    // pins are asynchronous to clk; only the second stage is read
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gpio_meta_q <= '1;
            gpio_sync_q <= '1;
        end else begin
            gpio_meta_q <= gpio_pin_i;
            gpio_sync_q <= gpio_meta_q;
        end
    end

    tdp_link_rx u_rx (
        .clk    (clk),
        .arst_n (arst_n),
        .lclk_s (gpio_sync_q[`TDP_CLK_PIN]),
        .ldat_s (gpio_sync_q[`TDP_DAT_PIN]),
        .lnk    (lnk.rx)
    );

    assign locked       = debug_disable_i || (part_state_i == part_run);
    assign wake         = pwr_off_q && !(&gpio_sync_q);
    // connect needs the led dark, else the host cannot see its own clock
    assign take_connect = is_cmd(lnk.cmd_valid, lnk.cmd, `TDP_CMD_CONNECT)
                          && !locked && !led_q && !pwr_off_q;
    assign take_disc    = is_cmd(lnk.cmd_valid, lnk.cmd, `TDP_CMD_DISCONNECT)
                          && session_q && !locked;
    assign take_reset   = is_cmd(lnk.cmd_valid, lnk.cmd, `TDP_CMD_RESET)
                          && session_q && !locked && (st_q == st_idle);

    // halt and led block share this one flop so they lift together
    always_comb begin
        session_d = session_q;
        if (locked || pwr_off_q || shutdown_req_i) begin
            session_d = 1'b0;
        end else if (take_connect) begin
            session_d = 1'b1;
        end else if (take_disc) begin
            session_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            session_q <= 1'b0;
        end else begin
            session_q <= session_d;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_valid_q <= 1'b0;
            ack_q       <= 1'b0;
        end else begin
            ack_valid_q <= lnk.cmd_valid;
            ack_q       <= take_connect || take_disc || take_reset;
        end
    end
    assign lnk.ack_valid = ack_valid_q;
    assign lnk.ack       = ack_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bp_clear_q <= 1'b0;
        end else begin
            bp_clear_q <= take_disc;
        end
    end

    // led follows user request unless blocked; same edge as halt release
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            led_q <= 1'b0;
        end else begin
            // dark on the very edge that power drops, not one cycle later
            led_q <= user_led_req_i && !session_d && !pwr_off_q
                     && !(shutdown_req_i && st_q == st_idle);
        end
    end

    // data pin: debug answer wins; user output is cut off while halted
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dat_o_q  <= 1'b0;
            dat_oe_q <= 1'b0;
        end else begin
            dat_o_q  <= lnk.drv_oe ? lnk.drv_val : user_dat_out_i;
            dat_oe_q <= lnk.drv_oe || (user_dat_oe_i && !session_q && !pwr_off_q);
        end
    end

    // shutdown drops digital power; ram content is lost on wake
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pwr_off_q <= 1'b0;
        end else if (wake) begin
            pwr_off_q <= 1'b0;
        end else if (shutdown_req_i && st_q == st_idle) begin
            pwr_off_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q      <= st_idle;
            rst_cnt_q <= 4'h0;
        end else begin
            unique case (st_q)
                st_idle: begin
                    if (take_reset || wake) begin
                        st_q      <= st_reset;
                        rst_cnt_q <= `TDP_RST_CYCLES - 4'h1;
                    end
                end
                st_reset: begin
                    if (rst_cnt_q == 4'h0) begin
                        st_q <= st_boot;
                    end else begin
                        rst_cnt_q <= rst_cnt_q - 4'h1;
                    end
                end
                st_boot: begin
                    if (boot_done_i) begin
                        st_q <= st_idle;
                    end
                end
                default: begin
                    st_q <= st_idle;
                end
            endcase
        end
    end

    // boot mode is latched at reset entry so a changing strap cannot split it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dig_rst_n_q <= 1'b1;
            boot_req_q  <= 1'b0;
            user_load_q <= 1'b0;
            ram_keep_q  <= 1'b0;
        end else begin
            dig_rst_n_q <= !(st_q == st_idle ? (take_reset || wake) : (st_q == st_reset && rst_cnt_q != 4'h0));
            boot_req_q  <= (st_q == st_reset && rst_cnt_q == 4'h0) || (st_q == st_boot && !boot_done_i);
            if (st_q == st_idle && (take_reset || wake)) begin
                user_load_q <= (part_state_i == part_user);
                ram_keep_q  <= (part_state_i == part_factory) && !wake;
            end
        end
    end

    assign gpio_in_o        = gpio_sync_q;
    assign dat_pin_o        = dat_o_q;
    assign dat_pin_oe       = dat_oe_q;
    assign led_drive_o      = led_q;
    assign core_halt_o      = session_q;
    assign bp_clear_o       = bp_clear_q;
    assign dig_rst_n_o      = dig_rst_n_q;
    assign boot_req_o       = boot_req_q;
    assign boot_user_load_o = user_load_q;
    assign ram_keep_o       = ram_keep_q;
    assign pwr_off_o        = pwr_off_q;

    AST_DISABLE_REFUSES: assert property (@(posedge clk) disable iff (!arst_n)
        lnk.cmd_valid && debug_disable_i |=> ack_valid_q && !ack_q)
        else $error("command accepted with debug disabled");

    AST_RUN_PART_REFUSES: assert property (@(posedge clk) disable iff (!arst_n)
        part_state_i == part_run |-> ##1 !(ack_valid_q && ack_q) && !$rose(core_halt_o))
        else $error("run part accepted debug access");

    AST_CONNECT_HALTS: assert property (@(posedge clk) disable iff (!arst_n)
        take_connect && !shutdown_req_i |=> core_halt_o && ack_q)
        else $error("connect did not halt the core");

    AST_LED_BLOCKED: assert property (@(posedge clk) disable iff (!arst_n)
        core_halt_o |-> !led_drive_o)
        else $error("led driver on during session");

    AST_CONNECT_NEEDS_DARK: assert property (@(posedge clk) disable iff (!arst_n)
        is_cmd(lnk.cmd_valid, lnk.cmd, `TDP_CMD_CONNECT) && led_drive_o && !core_halt_o
        |=> !core_halt_o && !ack_q)
        else $error("connect taken while led lit");

    AST_DISC_CLEARS_BP: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(core_halt_o) && !$past(locked) && !$past(pwr_off_q) && !$past(shutdown_req_i) |-> bp_clear_o)
        else $error("disconnect without breakpoint clear");

    AST_RELEASE_TOGETHER: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(core_halt_o) && $past(user_led_req_i) && !pwr_off_q |-> led_drive_o)
        else $error("led unblock not on the halt release edge");

    AST_RESET_LENGTH: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(dig_rst_n_o) |-> !dig_rst_n_o [*8] ##1 dig_rst_n_o && boot_req_o)
        else $error("digital reset pulse length wrong");

    AST_RESET_SOURCE: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(dig_rst_n_o) |-> $past(take_reset) || $past(wake))
        else $error("digital reset from unexpected source");

    AST_BOOT_MODE: assert property (@(posedge clk) disable iff (!arst_n)
        take_reset |=> boot_user_load_o == ($past(part_state_i) == part_user)
                       && ram_keep_o == ($past(part_state_i) == part_factory))
        else $error("boot mode does not match part state");

    AST_WAKE: assert property (@(posedge clk) disable iff (!arst_n)
        pwr_off_o && !(&gpio_sync_q) |=> !pwr_off_o ##1 !dig_rst_n_o)
        else $error("low pin did not wake from shutdown");

    AST_BP_ONE_PULSE: assert property (@(posedge clk) disable iff (!arst_n)
        bp_clear_o |=> !bp_clear_o)
        else $error("breakpoint clear longer than one cycle");

    AST_USER_OE_CUT: assert property (@(posedge clk) disable iff (!arst_n)
        $past(core_halt_o) && !$past(lnk.drv_oe) |-> !dat_pin_oe)
        else $error("user drove data pin during session");

    AST_OFF_DARK: assert property (@(posedge clk) disable iff (!arst_n)
        pwr_off_o |-> !core_halt_o && !led_drive_o)
        else $error("session or led active while powered off");

    AST_LOCK_DROPS: assert property (@(posedge clk) disable iff (!arst_n)
        locked |=> !core_halt_o)
        else $error("session kept while port locked");

    AST_BOOT_HOLDS: assert property (@(posedge clk) disable iff (!arst_n)
        boot_req_o && !boot_done_i |=> boot_req_o)
        else $error("boot request dropped before done");

    AST_BOOT_ENDS: assert property (@(posedge clk) disable iff (!arst_n)
        boot_req_o && boot_done_i |=> !boot_req_o)
        else $error("boot request kept after done");

    AST_ACK_ONLY_CMD: assert property (@(posedge clk) disable iff (!arst_n)
        ack_q |-> ack_valid_q)
        else $error("accept answer without a command");
endmodule

/* File: hw/tdp_defines.svh */
// timing, command and pin constants for the two-wire debug port
`ifndef TDP_DEFINES_SVH
`define TDP_DEFINES_SVH

`define TDP_CLK_PERIOD_NS 10
`define TDP_RST_TIME_NS   80
`define TDP_RST_CYCLES    4'((`TDP_RST_TIME_NS + `TDP_CLK_PERIOD_NS - 1) / `TDP_CLK_PERIOD_NS)
`define TDP_IDLE_TIME_NS  20000
`define TDP_IDLE_CYCLES   11'(`TDP_IDLE_TIME_NS / `TDP_CLK_PERIOD_NS)

`define TDP_CMD_CONNECT    8'ha5
`define TDP_CMD_DISCONNECT 8'h5a
`define TDP_CMD_RESET      8'h3c
`define TDP_FRAME_LAST     3'h7

`define TDP_GPIO_W   9
`define TDP_CLK_PIN  5
`define TDP_DAT_PIN  4

`endif

/* File: hw/tdp_pkg.sv */
// types shared by the debug port modules
package tdp_pkg;
    typedef enum logic [1:0] {
        part_factory = 2'b00,
        part_user    = 2'b01,
        part_run     = 2'b10
    } tdp_part_t;

    typedef enum logic [1:0] {
        st_idle  = 2'b00,
        st_reset = 2'b01,
        st_boot  = 2'b10
    } tdp_boot_st_t;

    typedef enum logic [1:0] {
        ak_none  = 2'b00,
        ak_wait  = 2'b01,
        ak_drive = 2'b10
    } tdp_ack_st_t;
endpackage

/* File: hw/tdp_link_if.sv */
// command and answer carrier between link receiver and controller
`timescale 1ns/10ps
interface tdp_link_if;
    logic       cmd_valid;
    logic [7:0] cmd;
    logic       ack_valid;
    logic       ack;
    logic       drv_oe;
    logic       drv_val;

    modport rx (output cmd_valid, output cmd, output drv_oe, output drv_val, input ack_valid, input ack);
    modport ctrl (input cmd_valid, input cmd, input drv_oe, input drv_val, output ack_valid, output ack);
endinterface

/* File: hw/tdp_link_rx.sv */
// debug link receiver: frames commands from sampled link clock and data
`timescale 1ns/10ps
`include "tdp_defines.svh"
module tdp_link_rx (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic lclk_s,
    input  wire logic ldat_s,
    tdp_link_if.rx    lnk
);
    import tdp_pkg::*;

    logic        lclk_prev_q;
    logic [7:0]  shift_q;
    logic [2:0]  bit_q;
    logic [10:0] idle_q;
    tdp_ack_st_t ack_st_q;
    logic        ack_val_q;
    logic        cmd_valid_q;
    logic        drv_oe_q;
    logic        drv_val_q;
    logic        rise;
    logic        fall;
    logic        timeout;

    assign rise    = lclk_s & ~lclk_prev_q;
    assign fall    = ~lclk_s & lclk_prev_q;
    assign timeout = (idle_q == `TDP_IDLE_CYCLES);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            // pin idles high; a low here would fake a rise right after reset
            lclk_prev_q <= 1'b1;
        end else begin
            lclk_prev_q <= lclk_s;
        end
    end

    // a stalled host clock drops a half frame so the next one aligns
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            idle_q <= 11'h000;
        end else if (rise || fall) begin
            idle_q <= 11'h000;
        end else if (!timeout) begin
            idle_q <= idle_q + 11'h001;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shift_q     <= 8'h00;
            bit_q       <= 3'h0;
            cmd_valid_q <= 1'b0;
        end else begin
            cmd_valid_q <= 1'b0;
            if (rise && ack_st_q == ak_none) begin
                shift_q <= {shift_q[6:0], ldat_s};
                // a rise that ends a long stall is the first bit of a fresh frame
                bit_q   <= timeout ? 3'h1 : bit_q + 3'h1;
                if (!timeout && bit_q == `TDP_FRAME_LAST) begin
                    cmd_valid_q <= 1'b1;
                end
            end else if (timeout) begin
                bit_q <= 3'h0;
            end
        end
    end

    // answer bit is driven for one link clock period, falling to falling
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_st_q  <= ak_none;
            ack_val_q <= 1'b0;
            drv_oe_q  <= 1'b0;
            drv_val_q <= 1'b0;
        end else if (timeout) begin
            ack_st_q <= ak_none;
            drv_oe_q <= 1'b0;
        end else begin
            unique case (ack_st_q)
                ak_none: begin
                    if (rise && bit_q == `TDP_FRAME_LAST) begin
                        ack_st_q  <= ak_wait;
                        ack_val_q <= 1'b0;
                    end
                end
                ak_wait: begin
                    if (lnk.ack_valid) begin
                        ack_val_q <= lnk.ack;
                    end
                    if (fall) begin
                        ack_st_q  <= ak_drive;
                        drv_oe_q  <= 1'b1;
                        drv_val_q <= lnk.ack_valid ? lnk.ack : ack_val_q;
                    end
                end
                ak_drive: begin
                    if (fall) begin
                        ack_st_q <= ak_none;
                        drv_oe_q <= 1'b0;
                    end
                end
                default: begin
                    ack_st_q <= ak_none;
                    drv_oe_q <= 1'b0;
                end
            endcase
        end
    end

    assign lnk.cmd_valid = cmd_valid_q;
    assign lnk.cmd       = shift_q;
    assign lnk.drv_oe    = drv_oe_q;
    assign lnk.drv_val   = drv_val_q;

    AST_NO_DRIVE_MIDFRAME: assert property (@(posedge clk) disable iff (!arst_n)
        drv_oe_q |-> bit_q == 3'h0)
        else $error("data line driven in the middle of a frame");
endmodule

/* File: tb/tdp_host_model.sv */
// host debug adapter model: drives link clock and data, reads the answer bit
`timescale 1ns/10ps
module tdp_host_model (
    input  wire logic attach,
    input  wire logic dat_pin_o,
    input  wire logic dat_pin_oe,
    output logic      lclk_pin,
    output logic      ldat_pin
);
    localparam real HALF = 62.5;
    logic lclk_q = 1'b0;
    logic hdat_q = 1'b1;
    logic hoe_q  = 1'b0;
    logic clash  = 1'b0;
    // unplugged cable: pad pull-up wins, clock stands still between frames
    assign lclk_pin = attach ? lclk_q : 1'b1;
    // no keeper on the data line, so a released line shows the inverse level
    always @(dat_pin_oe, dat_pin_o, hoe_q, hdat_q, attach) begin
        if (dat_pin_oe === 1'b1) ldat_pin = dat_pin_o;
        else if (!attach) ldat_pin = 1'b1;
        else if (hoe_q) ldat_pin = hdat_q;
        else ldat_pin = ~ldat_pin;
        if (dat_pin_oe === 1'b1 && hoe_q) clash = 1'b1;
    end
    // msb first, data held across the rising edge, released before the answer
    task automatic send(input logic [7:0] cmd, output logic ans);
        for (int i = 7; i >= 0; i--) begin
            hoe_q  = 1'b1;
            hdat_q = cmd[i];
            #(HALF);
            lclk_q = 1'b1;
            #(HALF);
            lclk_q = 1'b0;
        end
        hoe_q = 1'b0;
        #(HALF);
        lclk_q = 1'b1;
        ans = ldat_pin;
        #(HALF);
        lclk_q = 1'b0;
        #(2*HALF);
    endtask
endmodule

/* File: tb/tb_two_wire_debug_pin_sharing.sv */
// self-checking bench for the two-wire debug port
`timescale 1ns/10ps
`include "tdp_defines.svh"
module tb_two_wire_debug_pin_sharing;
    import tdp_pkg::*;
    logic       clk       = 1'b0;
    logic       arst_n    = 1'b0;
    logic       attach    = 1'b0;
    logic [8:0] user_pins = 9'h1ff;
    logic       user_led  = 1'b0;
    logic       user_dat  = 1'b0;
    logic       user_oe   = 1'b0;
    tdp_part_t  part      = part_factory;
    logic       dbg_dis   = 1'b0;
    logic       shut_req  = 1'b0;
    logic       boot_done = 1'b0;
    logic       watch     = 1'b0;
    logic       lclk_pin;
    logic       ldat_pin;
    logic [8:0] gpio_in;
    logic       dat_o;
    logic       dat_oe;
    logic       led;
    logic       halt;
    logic       bp_clr;
    logic       rst_n;
    logic       boot_req;
    logic       user_load;
    logic       ram_keep;
    logic       pwr_off;
    logic       keep_at;
    logic       load_at;
    logic       boot_at;
    logic       halt_prev;
    logic       ans;
    int         errors    = 0;
    int         cmp_count = 0;
    int         low_cnt   = 0;
    int         rst_len   = 0;
    int         rst_seen  = 0;
    int         disc_seen = 0;

    always #5 clk = ~clk;

    tdp_host_model host (
        .attach     (attach),
        .dat_pin_o  (dat_o),
        .dat_pin_oe (dat_oe),
        .lclk_pin   (lclk_pin),
        .ldat_pin   (ldat_pin)
    );

    tdp_debug_port dut (
        .clk              (clk),
        .arst_n           (arst_n),
        .gpio_pin_i       ({user_pins[8:6], lclk_pin, ldat_pin, user_pins[3:0]}),
        .user_led_req_i   (user_led),
        .user_dat_out_i   (user_dat),
        .user_dat_oe_i    (user_oe),
        .part_state_i     (part),
        .debug_disable_i  (dbg_dis),
        .shutdown_req_i   (shut_req),
        .boot_done_i      (boot_done),
        .gpio_in_o        (gpio_in),
        .dat_pin_o        (dat_o),
        .dat_pin_oe       (dat_oe),
        .led_drive_o      (led),
        .core_halt_o      (halt),
        .bp_clear_o       (bp_clr),
        .dig_rst_n_o      (rst_n),
        .boot_req_o       (boot_req),
        .boot_user_load_o (user_load),
        .ram_keep_o       (ram_keep),
        .pwr_off_o        (pwr_off)
    );

    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_vec(input logic [8:0] got, input logic [8:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // measures each digital reset pulse and what was latched with it;
    // sampled mid-cycle so no output is read on the edge that launches it
    always @(negedge clk) begin
        halt_prev <= halt;
        if (rst_n === 1'b0) begin
            low_cnt <= low_cnt + 1;
        end else if (low_cnt != 0) begin
            rst_len  <= low_cnt;
            rst_seen <= rst_seen + 1;
            low_cnt  <= 0;
            keep_at  <= ram_keep;
            load_at  <= user_load;
            boot_at  <= boot_req;
        end
        if (watch && halt_prev === 1'b1 && halt === 1'b0) begin
            disc_seen++;
            chk_bit(led, user_led);
            chk_bit(bp_clr, 1'b1);
        end
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask

    // bounded: a missing pulse shows up in the count check afterwards
    task automatic wait_rst(input int n0);
        for (int k = 0; k < 100 && rst_seen == n0; k++) @(negedge clk);
        chk_vec(9'(rst_seen), 9'(n0 + 1));
    endtask

    task automatic pulse_boot();
        @(negedge clk);
        boot_done = 1'b1;
        @(negedge clk);
        boot_done = 1'b0;
        wait_clk(2);
    endtask

    task automatic t_led();
        @(negedge clk);
        user_led = 1'b1;
        attach   = 1'b1;
        wait_clk(4);
        chk_bit(led, 1'b1);
        host.send(`TDP_CMD_CONNECT, ans);
        chk_bit(ans, 1'b0);
        chk_bit(halt, 1'b0);
        @(negedge clk);
        user_led = 1'b0;
        wait_clk(4);
        host.send(`TDP_CMD_CONNECT, ans);
        chk_bit(ans, 1'b1);
        chk_bit(halt, 1'b1);
        @(negedge clk);
        user_led = 1'b1;
        user_oe  = 1'b1;
        user_dat = 1'b1;
        wait_clk(4);
        chk_bit(led, 1'b0);
        chk_bit(dat_oe, 1'b0);
        // host owns the data line until the falling clock edge that ends its eighth bit
        user_oe = 1'b0;
        watch   = 1'b1;
        host.send(`TDP_CMD_DISCONNECT, ans);
        watch = 1'b0;
        chk_bit(ans, 1'b1);
        chk_vec(9'(disc_seen), 9'h001);
        chk_bit(led, 1'b1);
        chk_bit(halt, 1'b0);
        @(negedge clk);
        user_oe = 1'b1;
        wait_clk(2);
        chk_bit(dat_oe, 1'b1);
        chk_bit(dat_o, 1'b1);
        @(negedge clk);
        user_oe  = 1'b0;
        user_dat = 1'b0;
        wait_clk(4);
        host.send(`TDP_CMD_CONNECT, ans);
        chk_bit(ans, 1'b0);
        @(negedge clk);
        user_led = 1'b0;
        wait_clk(4);
        $display("test led sharing done");
    endtask

    task automatic t_lock();
        int n;
        @(negedge clk);
        dbg_dis = 1'b1;
        host.send(`TDP_CMD_CONNECT, ans);
        chk_bit(ans, 1'b0);
        @(negedge clk);
        dbg_dis = 1'b0;
        part    = part_run;
        host.send(`TDP_CMD_CONNECT, ans);
        chk_bit(ans, 1'b0);
        chk_bit(halt, 1'b0);
        @(negedge clk);
        part = part_factory;
        host.send(8'h00, ans);
        chk_bit(ans, 1'b0);
        n = rst_seen;
        host.send(`TDP_CMD_RESET, ans);
        chk_bit(ans, 1'b0);
        chk_vec(9'(rst_seen), 9'(n));
        host.send(`TDP_CMD_DISCONNECT, ans);
        chk_bit(ans, 1'b0);
        host.send(`TDP_CMD_CONNECT, ans);
        chk_bit(ans, 1'b1);
        @(negedge clk);
        dbg_dis = 1'b1;
        wait_clk(5);
        chk_bit(halt, 1'b0);
        dbg_dis = 1'b0;
        $display("test lockout done");
    endtask

    task automatic t_boot();
        int n;
        for (int p = 0; p < 2; p++) begin
            @(negedge clk);
            part = tdp_part_t'(p);
            host.send(`TDP_CMD_CONNECT, ans);
            n = rst_seen;
            host.send(`TDP_CMD_RESET, ans);
            chk_bit(ans, 1'b1);
            wait_rst(n);
            chk_vec(9'(rst_len), 9'h008);
            chk_bit(boot_at, 1'b1);
            chk_bit(keep_at, 1'(p == 0));
            chk_bit(load_at, 1'(p == 1));
            chk_bit(halt, 1'b1);
            host.send(`TDP_CMD_RESET, ans);
            chk_bit(ans, 1'b0);
            chk_bit(boot_req, 1'b1);
            pulse_boot();
            chk_bit(boot_req, 1'b0);
            host.send(`TDP_CMD_DISCONNECT, ans);
        end
        $display("test debug reset done");
    endtask

    task automatic t_shut();
        int n;
        @(negedge clk);
        attach   = 1'b0;
        user_led = 1'b1;
        wait_clk(2100);
        shut_req = 1'b1;
        @(negedge clk);
        shut_req = 1'b0;
        wait_clk(20);
        chk_bit(pwr_off, 1'b1);
        chk_bit(led, 1'b0);
        n = rst_seen;
        user_pins[0] = 1'b0;
        wait_rst(n);
        chk_bit(pwr_off, 1'b0);
        chk_vec(9'(rst_len), 9'h008);
        chk_bit(keep_at, 1'b0);
        user_pins[0] = 1'b1;
        user_led     = 1'b0;
        pulse_boot();
        $display("test shutdown wake done");
    endtask

    initial begin
        repeat (6) @(negedge clk);
        arst_n = 1'b1;
        wait_clk(3);
        chk_vec(gpio_in, 9'h1ff);
        chk_bit(halt, 1'b0);
        chk_bit(rst_n, 1'b1);
        chk_bit(pwr_off, 1'b0);
        t_led();
        t_lock();
        t_boot();
        t_shut();
        chk_bit(host.clash, 1'b0);
        complete_run();
    end

    // whole run is about 44 us; allow over four times that
    initial begin
        #200000;
        errors++;
        complete_run();
    end
endmodule
